// ===== index_data_port.sv
// Purpose: Index/data I/O port pair decode for the strap registers
// Assumes: One-cycle io_write/io_read strobes synchronous to sys_clk
// Notes:   Strobes to the data port are passed on combinationally
`timescale 1ns/1ps
`default_nettype none
module index_data_port
    import strap_option_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // I/O cycle
    input wire logic [15:0] io_addr,
    input wire logic io_write,
    input wire logic io_read,
    input wire logic [7:0] io_wdata,
    // Register side
    output logic [7:0] reg_index,
    output logic data_write,
    output logic data_read,
    output logic index_read
);

    typedef struct packed {
        logic [7:0] index;
    } port_state_type;

    port_state_type st_q;
    port_state_type st_d;

    // ------------------------------------------------------------
    // Index latch
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        if (io_write && io_addr == PORT_INDEX) begin
            st_d.index = io_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '{index: INDEX_RESET};
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_index = st_q.index;
    assign data_write = io_write && io_addr == PORT_DATA;
    assign data_read = io_read && io_addr == PORT_DATA;
    assign index_read = io_read && io_addr == PORT_INDEX;

endmodule
`default_nettype wire

// ===== pci_clock_divider.sv
// Purpose: Derive the PCI clock from the host clock by two or three
// Assumes: sys_clk stands for the host clock
// Notes:   Divide by three gives a one-third duty high pulse
`timescale 1ns/1ps
`default_nettype none
module pci_clock_divider
    import strap_option_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Divisor select: low halves, high thirds
    input wire logic divide_by_three,
    // Divided clock
    output logic pci_clk_out
);

    typedef struct packed {
        logic [1:0] count;
        logic clk_out;
    } div_state_type;

    div_state_type st_q;
    div_state_type st_d;
    logic [1:0] last;

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        last = divide_by_three ? DIV_LAST_THIRD : DIV_LAST_HALF;
        if (st_q.count >= last) begin
            st_d.count = DIV_COUNT_ZERO;
        end else begin
            st_d.count = st_q.count + DIV_COUNT_ONE;
        end
        st_d.clk_out = (st_d.count == DIV_COUNT_ZERO);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '{count: DIV_COUNT_ZERO, clk_out: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign pci_clk_out = st_q.clk_out;

endmodule
`default_nettype wire

// ===== strap_board_model.sv
// Purpose: Board side of the strap lines: resistor levels, then memory traffic
// Assumes: Strap levels come from the testbench, pull levels already applied
// Notes:   After the hold window the lines change every cycle, never a stale value
`timescale 1ns/1ps
`default_nettype none
module strap_board_model (
    // Clock
    input wire logic sys_clk,
    // Device reset output marks the end of the strap hold window
    input wire logic system_reset_output_n,
    // Levels set by the board resistors
    input wire logic [43:0] strap_setting,
    // Shared memory data lines
    output logic [43:0] memory_data_strap_lines
);
    // ------------------------------------------------------------
    // Line levels
    // ------------------------------------------------------------
    // Busy memory traffic, so a late capture cannot pass for a strap value
    logic [43:0] bus_noise_q = 44'h5A5A5A5A5A5;

    always @(posedge sys_clk) begin
        bus_noise_q <= ~{bus_noise_q[42:0], bus_noise_q[43]};
    end

    // Straps held from reset input release until reset output high
    assign memory_data_strap_lines = system_reset_output_n ? bus_noise_q : strap_setting;
endmodule
`default_nettype wire

// ===== strap_option_capture.sv
// Purpose: Capture board straps on memory data lines during system reset
// Assumes: Strap lines and reset input are synchronous to sys_clk
// Notes:   Straps are only captured while the reset input is low
`timescale 1ns/1ps
`default_nettype none
// Function
// - Line 40 low selects single-speed core, high selects doubled core clock.
// - Index 4Ah shows captured lines 7..2 in bits 7..2.
// - Index 4Ah: bit7 module0 type, 6-5 speed, 4 module1 type, 3-2 speed.
// - Module speed/type straps drive nothing but software-readable registers.
// - Index 4Bh shows lines 15..10 as module 2 and 3 type/speed.
// - Index 4Ch bits 4..0 show lines 20..16, bit 5 shows line 23.
// - Only bit 4 of index 4Ch takes software writes.
// - Index 4Ch bit 1 sets PCI clock to host clock /2 or /3.
// - Index 5Fh bits 5..3 show host clock select lines, driving synthesizer.
// - Line 0 selects bus memory write strobe or display colour key.
// - Lines 27..39 and 41..43 have no function.
// - Straps sampled while reset input low; board holds them until release.
module strap_option_capture
    import strap_option_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Board straps and system reset
    input wire logic [STRAP_LINES-1:0] memory_data_strap_lines,
    input wire logic system_reset_input_n,
    output logic system_reset_output_n,
    // Index/data I/O port
    input wire logic [15:0] io_addr,
    input wire logic io_write,
    input wire logic io_read,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic io_rdata_valid,
    // Strap-selected functions
    output logic core_clock_double,
    output logic isa_memory_write_strobe_select,
    output logic pci_divide_by_three,
    output logic [2:0] host_clock_select,
    output logic pci_clk_out
);

    typedef struct packed {
        phase_type phase;
        logic [7:0] delay_count;
        logic [5:0] module_low;
        logic [5:0] module_high;
        logic [5:0] bus_divisor;
        logic [2:0] host_clock;
        logic core_double;
        logic bus_function;
        logic [7:0] rdata;
        logic rdata_valid;
        logic reset_out_n;
    } cap_state_type;

    localparam cap_state_type CAP_RESET = '{
        phase: PH_SAMPLE,
        delay_count: COUNT_ZERO,
        module_low: FIELD6_RESET,
        module_high: FIELD6_RESET,
        bus_divisor: FIELD6_RESET,
        host_clock: FIELD3_RESET,
        core_double: 1'b0,
        bus_function: 1'b0,
        rdata: BYTE_RESET,
        rdata_valid: 1'b0,
        reset_out_n: 1'b0
    };

    cap_state_type st_q;
    cap_state_type st_d;
    logic [7:0] reg_index;
    logic data_write;
    logic data_read;
    logic index_read;
    logic [7:0] read_value;
    logic sampling;

    // ------------------------------------------------------------
    // Port decode
    // ------------------------------------------------------------
    index_data_port u_port (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .io_addr(io_addr),
        .io_write(io_write),
        .io_read(io_read),
        .io_wdata(io_wdata),
        .reg_index(reg_index),
        .data_write(data_write),
        .data_read(data_read),
        .index_read(index_read)
    );

    // ------------------------------------------------------------
    // Capture, reset sequencing and register access
    // ------------------------------------------------------------
    // Lines 27..39 and 41..43 are deliberately never looked at
    assign sampling = !system_reset_input_n;

    always_comb begin
        st_d = st_q;
        st_d.rdata_valid = 1'b0;
        unique case (reg_index)
            IDX_MODULE_LOW: read_value = {st_q.module_low, RSV_LOW_PAIR};
            IDX_MODULE_HIGH: read_value = {st_q.module_high, RSV_LOW_PAIR};
            IDX_BUS_DIVISOR: read_value = {RSV_LOW_PAIR, st_q.bus_divisor};
            IDX_HOST_CLOCK: read_value = {RSV_LOW_PAIR, st_q.host_clock, RSV_LOW_TRIPLE};
            default: read_value = UNMAPPED_READ;
        endcase
        // Board may still be settling, so keep taking levels while reset is held
        if (sampling) begin
            st_d.phase = PH_SAMPLE;
            st_d.delay_count = COUNT_ZERO;
            st_d.reset_out_n = 1'b0;
            st_d.module_low = memory_data_strap_lines[LOW_MSB:LOW_LSB];
            st_d.module_high = memory_data_strap_lines[HIGH_MSB:HIGH_LSB];
            st_d.bus_divisor = {memory_data_strap_lines[LINE_DIV_EXTRA],
                                memory_data_strap_lines[DIV_MSB:DIV_LSB]};
            st_d.host_clock = memory_data_strap_lines[HCLK_MSB:HCLK_LSB];
            st_d.core_double = memory_data_strap_lines[LINE_CORE_MULT];
            st_d.bus_function = memory_data_strap_lines[LINE_BUS_FUNCTION];
        end else begin
            unique case (st_q.phase)
                PH_SAMPLE: begin
                    st_d.phase = PH_STRETCH;
                    st_d.delay_count = COUNT_ZERO;
                end
                PH_STRETCH: begin
                    // Release is held back so the board keeps straps steady meanwhile
                    if (st_q.delay_count == RESET_OUT_LAST) begin
                        st_d.phase = PH_RUN;
                        st_d.reset_out_n = 1'b1;
                    end else begin
                        st_d.delay_count = st_q.delay_count + COUNT_ONE;
                    end
                end
                PH_RUN: begin
                    st_d.reset_out_n = 1'b1;
                end
                default: begin
                    st_d.phase = PH_SAMPLE;
                end
            endcase
            // Captured values win over software until sampling ends
            if (data_write && reg_index == IDX_BUS_DIVISOR) begin
                st_d.bus_divisor[DIV_WRITABLE_BIT] = io_wdata[DIV_WRITABLE_BIT];
            end
            // Other indexes keep their captured bytes on write
        end
        if (data_read) begin
            st_d.rdata = read_value;
            st_d.rdata_valid = 1'b1;
        end else if (index_read) begin
            st_d.rdata = reg_index;
            st_d.rdata_valid = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= CAP_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Strap-selected functions
    // ------------------------------------------------------------
    // Module speed and type bits feed only the read path
    assign core_clock_double = st_q.core_double;
    assign isa_memory_write_strobe_select = st_q.bus_function;
    assign pci_divide_by_three = st_q.bus_divisor[DIV_PCI_BIT];
    assign host_clock_select = st_q.host_clock;
    assign system_reset_output_n = st_q.reset_out_n;
    assign io_rdata = st_q.rdata;
    assign io_rdata_valid = st_q.rdata_valid;

    pci_clock_divider u_pci_div (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .divide_by_three(st_q.bus_divisor[DIV_PCI_BIT]),
        .pci_clk_out(pci_clk_out)
    );

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    a_core_mult_follow: assert property (
        sampling |=> core_clock_double == $past(memory_data_strap_lines[LINE_CORE_MULT]))
        else $error("core multiplier not taken from strap");

    a_core_mult_hold: assert property (
        !sampling |=> $stable(core_clock_double))
        else $error("core multiplier changed outside sampling");

    a_low_read_value: assert property (
        (data_read && reg_index == IDX_MODULE_LOW && !sampling)
        |=> io_rdata_valid && io_rdata == {st_q.module_low, 2'b00})
        else $error("module low register read wrong");

    a_low_rsv_zero: assert property (
        (data_read && reg_index == IDX_MODULE_LOW) |=> io_rdata[1:0] == 2'b00)
        else $error("module low reserved bits not zero");

    a_low_capture: assert property (
        sampling |=> st_q.module_low == $past(memory_data_strap_lines[LOW_MSB:LOW_LSB]))
        else $error("module low capture wrong");

    a_high_capture: assert property (
        sampling |=> st_q.module_high == $past(memory_data_strap_lines[15:10]))
        else $error("module high capture wrong");

    a_high_read_value: assert property (
        (data_read && reg_index == IDX_MODULE_HIGH && !sampling)
        |=> io_rdata_valid && io_rdata == {st_q.module_high, RSV_LOW_PAIR})
        else $error("module high register read wrong");

    a_div_capture: assert property (
        sampling |=> st_q.bus_divisor == {$past(memory_data_strap_lines[23]),
                                          $past(memory_data_strap_lines[20:16])})
        else $error("divisor register capture wrong");

    a_div_read_value: assert property (
        (data_read && !data_write && reg_index == IDX_BUS_DIVISOR && !sampling)
        |=> io_rdata_valid && io_rdata == {RSV_LOW_PAIR, st_q.bus_divisor})
        else $error("divisor register read wrong");

    a_div_write_mask: assert property (
        (data_write && reg_index == IDX_BUS_DIVISOR && !sampling)
        |=> st_q.bus_divisor[4] == $past(io_wdata[4])
            && st_q.bus_divisor[3:0] == $past(st_q.bus_divisor[3:0])
            && st_q.bus_divisor[5] == $past(st_q.bus_divisor[5]))
        else $error("divisor register write mask wrong");

    a_pci_half: assert property (
        (!sampling && !pci_divide_by_three && pci_clk_out)
        ##1 (!sampling && !pci_divide_by_three) |-> !pci_clk_out ##1 pci_clk_out)
        else $error("pci clock not host clock over two");

    a_pci_third: assert property (
        (!sampling && pci_divide_by_three && pci_clk_out)
        ##1 (!sampling && pci_divide_by_three)
        |-> !pci_clk_out ##1 !pci_clk_out ##1 pci_clk_out)
        else $error("pci clock not host clock over three");

    a_pci_div_hold: assert property (
        !sampling |=> $stable(pci_divide_by_three))
        else $error("pci divisor changed outside sampling");

    a_hclk_capture: assert property (
        sampling |=> host_clock_select == $past(memory_data_strap_lines[26:24]))
        else $error("host clock select capture wrong");

    a_hclk_read_value: assert property (
        (data_read && reg_index == IDX_HOST_CLOCK && !sampling)
        |=> io_rdata_valid && io_rdata == {RSV_LOW_PAIR, host_clock_select, RSV_LOW_TRIPLE})
        else $error("host clock register read wrong");

    a_bus_function: assert property (
        sampling |=> isa_memory_write_strobe_select == $past(memory_data_strap_lines[0]))
        else $error("bus function select capture wrong");

    a_reset_out_hold: assert property (
        $fell(system_reset_input_n) |=> !system_reset_output_n [*3])
        else $error("reset output not held during sampling");

    a_reset_out_late: assert property (
        $rose(system_reset_input_n) |-> ##1 !system_reset_output_n ##1 !system_reset_output_n)
        else $error("reset output released too early");

    a_reset_out_drop: assert property (
        sampling |=> !system_reset_output_n)
        else $error("reset output not driven low while sampling");

    a_reset_out_release: assert property (
        $rose(system_reset_output_n)
        |-> $past(system_reset_input_n) && $past(system_reset_input_n, 2))
        else $error("reset output released while reset input low");

    a_ro_ignore: assert property (
        (data_write && reg_index != IDX_BUS_DIVISOR && !sampling)
        |=> st_q.module_low == $past(st_q.module_low)
            && st_q.module_high == $past(st_q.module_high)
            && host_clock_select == $past(host_clock_select))
        else $error("read-only strap register changed on write");

    c_read_divisor: cover property (data_read && reg_index == IDX_BUS_DIVISOR);
    c_write_divisor: cover property (data_write && reg_index == IDX_BUS_DIVISOR && !sampling);
    c_reset_release: cover property ($rose(system_reset_output_n));
    c_third_clock: cover property (pci_divide_by_three && $rose(pci_clk_out));
    c_core_double: cover property (sampling ##1 core_clock_double);

endmodule
`default_nettype wire

// ===== strap_option_pkg.sv
// Purpose: Shared constants for the strap option capture block
// Assumes: Index/data I/O port pair, 8-bit registers, 125 MHz sys_clk
// Notes:   Reset values of captured registers are all zero until sampling runs
package strap_option_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLOCK_MHZ = 125;
    localparam int RESET_OUT_DELAY_NS = 1000;
    localparam int RESET_OUT_DELAY_CYCLES = (RESET_OUT_DELAY_NS * CLOCK_MHZ) / 1000;
    localparam logic [7:0] RESET_OUT_LAST = 8'(RESET_OUT_DELAY_CYCLES - 1);
    localparam logic [7:0] COUNT_ZERO = 8'h00;
    localparam logic [7:0] COUNT_ONE = 8'h01;

    // ------------------------------------------------------------
    // I/O ports and register indexes
    // ------------------------------------------------------------
    localparam logic [15:0] PORT_INDEX = 16'h0022;
    localparam logic [15:0] PORT_DATA = 16'h0023;
    localparam logic [7:0] IDX_MODULE_LOW = 8'h4A;
    localparam logic [7:0] IDX_MODULE_HIGH = 8'h4B;
    localparam logic [7:0] IDX_BUS_DIVISOR = 8'h4C;
    localparam logic [7:0] IDX_HOST_CLOCK = 8'h5F;
    localparam logic [7:0] INDEX_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'hFF;

    // ------------------------------------------------------------
    // Strap line positions
    // ------------------------------------------------------------
    localparam int STRAP_LINES = 44;
    localparam int LINE_BUS_FUNCTION = 0;
    localparam int LOW_MSB = 7;
    localparam int LOW_LSB = 2;
    localparam int HIGH_MSB = 15;
    localparam int HIGH_LSB = 10;
    localparam int DIV_MSB = 20;
    localparam int DIV_LSB = 16;
    localparam int LINE_DIV_EXTRA = 23;
    localparam int HCLK_MSB = 26;
    localparam int HCLK_LSB = 24;
    localparam int LINE_CORE_MULT = 40;

    // ------------------------------------------------------------
    // Register field positions and reset values
    // ------------------------------------------------------------
    localparam int DIV_WRITABLE_BIT = 4;
    localparam int DIV_PCI_BIT = 1;
    localparam logic [1:0] RSV_LOW_PAIR = 2'h0;
    localparam logic [2:0] RSV_LOW_TRIPLE = 3'h0;
    localparam logic [5:0] FIELD6_RESET = 6'h00;
    localparam logic [2:0] FIELD3_RESET = 3'h0;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // ------------------------------------------------------------
    // PCI clock divider
    // ------------------------------------------------------------
    localparam logic [1:0] DIV_LAST_HALF = 2'h1;
    localparam logic [1:0] DIV_LAST_THIRD = 2'h2;
    localparam logic [1:0] DIV_COUNT_ZERO = 2'h0;
    localparam logic [1:0] DIV_COUNT_ONE = 2'h1;

    typedef enum logic [1:0] {
        PH_SAMPLE = 2'b00,
        PH_STRETCH = 2'b01,
        PH_RUN = 2'b10
    } phase_type;

endpackage

// ===== test_strap_option_capture.sv
// Purpose: Self-checking bench for the strap option capture block
// Assumes: Index/data port strobes one cycle wide, inputs driven 1 ns after edges
// Notes:   Read results are queued by the driver and compared by a monitor
`timescale 1ns/1ps
`default_nettype none
module test_strap_option_capture;
    import strap_option_pkg::*;
    // Reserved lines and the ones among them pulled high
    localparam logic [43:0] RSV_MASK = 44'hEFFF8000000;
    localparam logic [43:0] PULL_UP = 44'h4F200000000;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic sys_rst_in_n = 1'b0;
    logic [43:0] strap_setting = 44'h00000000000;
    logic [43:0] strap_lines;
    logic [15:0] io_addr = 16'h0000;
    logic io_write = 1'b0;
    logic io_read = 1'b0;
    logic [7:0] io_wdata = 8'h00;
    logic [7:0] io_rdata;
    logic io_rdata_valid;
    logic reset_out_n;
    logic core_double;
    logic isa_sel;
    logic pci_div3;
    logic [2:0] host_sel;
    logic pci_clk;
    int errors = 0;
    int checked = 0;
    int seed = 49;
    logic [7:0] exp_q[$];

    always #4 sys_clk = ~sys_clk;

    strap_board_model board (.sys_clk(sys_clk), .system_reset_output_n(reset_out_n),
        .strap_setting(strap_setting), .memory_data_strap_lines(strap_lines));

    strap_option_capture uut (.sys_clk(sys_clk), .rst_n(rst_n),
        .memory_data_strap_lines(strap_lines), .system_reset_input_n(sys_rst_in_n),
        .system_reset_output_n(reset_out_n), .io_addr(io_addr), .io_write(io_write),
        .io_read(io_read), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .io_rdata_valid(io_rdata_valid), .core_clock_double(core_double),
        .isa_memory_write_strobe_select(isa_sel), .pci_divide_by_three(pci_div3),
        .host_clock_select(host_sel), .pci_clk_out(pci_clk));

    // ------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------
    task automatic end_of_test();
        if (errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // ------------------------------------------------------------
    // Port cycles
    // ------------------------------------------------------------
    task automatic io_cycle(input logic [15:0] a, input logic w, input logic r,
                            input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        io_addr = a;
        io_write = w;
        io_read = r;
        io_wdata = d;
        @(posedge sys_clk);
        #1;
        io_write = 1'b0;
        io_read = 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] idx, input logic [7:0] exp);
        io_cycle(PORT_INDEX, 1'b1, 1'b0, idx);
        exp_q.push_back(exp);
        io_cycle(PORT_DATA, 1'b0, 1'b1, 8'h00);
    endtask

    task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
        io_cycle(PORT_INDEX, 1'b1, 1'b0, idx);
        io_cycle(PORT_DATA, 1'b1, 1'b0, d);
    endtask

    // Bounded wait step; running out of cycles ends the run
    task automatic step(inout int k, input int lim);
        @(posedge sys_clk);
        #1;
        k++;
        if (k > lim) begin
            errors++;
            end_of_test();
        end
    endtask

    task automatic pci_period(output int p);
        int k;
        k = 0;
        p = 0;
        while (pci_clk !== 1'b0) step(k, 20);
        while (pci_clk !== 1'b1) step(k, 20);
        while (pci_clk === 1'b1) step(p, 20);
        while (pci_clk !== 1'b1) step(p, 20);
    endtask

    // ------------------------------------------------------------
    // Read monitor
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (io_rdata_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                errors++;
                $display("[ERR] io_rdata expected none seen %h", io_rdata);
            end else begin
                chk("io_rdata", exp_q.pop_front(), io_rdata);
            end
        end
    end

    initial begin
        repeat (100000) @(posedge sys_clk);
        errors++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [63:0] r;
        logic [43:0] v;
        logic [7:0] idx_tab[3];
        logic [7:0] exp_tab[3];
        int n;
        int p;
        repeat (20) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        for (int t = 0; t < 4; t++) begin
            r = {$random(seed), $random(seed)};
            v = r[43:0];
            v[40] = t[0];
            v[17] = t[1];
            v = (v & ~RSV_MASK) | PULL_UP;
            @(posedge sys_clk);
            #1;
            strap_setting = v;
            sys_rst_in_n = 1'b0;
            repeat (6) @(posedge sys_clk);
            #1;
            sys_rst_in_n = 1'b1;
            n = 0;
            while (reset_out_n !== 1'b1) step(n, 300);
            chk("reset_out_delay", 8'h01, {7'h00, (n == RESET_OUT_DELAY_CYCLES + 1)});
            chk("core_clock_double", {7'h00, v[40]}, {7'h00, core_double});
            chk("isa_select", {7'h00, v[0]}, {7'h00, isa_sel});
            chk("pci_divide_by_three", {7'h00, v[17]}, {7'h00, pci_div3});
            chk("host_clock_select", {5'h00, v[26:24]}, {5'h00, host_sel});
            idx_tab = '{IDX_MODULE_LOW, IDX_MODULE_HIGH, IDX_HOST_CLOCK};
            exp_tab = '{{v[7:2], 2'h0}, {v[15:10], 2'h0}, {2'h0, v[26:24], 3'h0}};
            for (int i = 0; i < 3; i++) begin
                rd_reg(idx_tab[i], exp_tab[i]);
                wr_reg(idx_tab[i], ~exp_tab[i]);
                rd_reg(idx_tab[i], exp_tab[i]);
            end
            rd_reg(IDX_BUS_DIVISOR, {2'h0, v[23], v[20:16]});
            wr_reg(IDX_BUS_DIVISOR, 8'hFF);
            rd_reg(IDX_BUS_DIVISOR, {2'h0, v[23], 1'b1, v[19:16]});
            wr_reg(IDX_BUS_DIVISOR, 8'h00);
            rd_reg(IDX_BUS_DIVISOR, {2'h0, v[23], 1'b0, v[19:16]});
            chk("pci_divide_after_write", {7'h00, v[17]}, {7'h00, pci_div3});
            pci_period(p);
            chk("pci_clk_period", v[17] ? 8'h03 : 8'h02, 8'(p));
            // Index port reads back the index; an unmapped index reads all ones
            io_cycle(PORT_INDEX, 1'b1, 1'b0, 8'h4D);
            exp_q.push_back(8'h4D);
            io_cycle(PORT_INDEX, 1'b0, 1'b1, 8'h00);
            exp_q.push_back(UNMAPPED_READ);
            io_cycle(PORT_DATA, 1'b0, 1'b1, 8'h00);
        end
        repeat (4) @(posedge sys_clk);
        chk("pending_reads", 8'h00, 8'(exp_q.size()));
        end_of_test();
    end
endmodule
`default_nettype wire
